// ===== hw/usbeb_buf.sv
// byte fifo used for every endpoint buffer layer
// assumes: DEPTH a power of two; one clock, async high reset
`timescale 1ns/1ns
module usbeb_buf #(
  parameter int DEPTH = 8,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clr,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic [CW-1:0] count,
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic wr_ok;
  logic rd_ok;

  // overflow and underflow are dropped, never wrap the count
  assign wr_ok = wr && (cnt_r != CW'(DEPTH));
  assign rd_ok = rd && (cnt_r != '0);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (clr) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_r + AW'(wr_ok);
      rp_r <= rp_r + AW'(rd_ok);
      cnt_r <= cnt_r + CW'(wr_ok) - CW'(rd_ok);
    end
  end

  always_ff @(posedge clk) begin
    if (wr_ok && !clr) begin
      mem[wp_r] <= wdata;
    end
  end

  assign rdata = mem[rp_r];
  assign count = cnt_r;
  assign empty = (cnt_r == '0);
  assign full = (cnt_r == CW'(DEPTH));
endmodule : usbeb_buf

// ===== hw/usbeb_consts.svh
// register offsets, field positions, reset values of the endpoint block
// assumes: included by bare name from the core and the assertion files
`ifndef USBEB_CONSTS_SVH
`define USBEB_CONSTS_SVH
`define USBEB_OFS_SETUP0 8'h00
`define USBEB_OFS_SETUP7 8'h07
`define USBEB_OFS_EP0STAT 8'h08
`define USBEB_OFS_PR 8'h09
`define USBEB_OFS_IST 8'h0a
`define USBEB_OFS_IEN 8'h0b
`define USBEB_OFS_EP0TGL 8'h0c
`define USBEB_OFS_EP0MP 8'h0d
`define USBEB_OFS_EP0CNT 8'h0e
`define USBEB_OFS_FST1 8'h0f
`define USBEB_OFS_FST2 8'h10
`define USBEB_OFS_EP0BUF 8'h11
`define USBEB_OFS_EP1CFG 8'h12
`define USBEB_OFS_BULK_ONE_TOGGLE 8'h13
`define USBEB_OFS_EP1MP 8'h14
`define USBEB_OFS_EP1CNT 8'h15
`define USBEB_OFS_EP1BUF 8'h16
`define USBEB_OFS_EP2CFG 8'h17
`define USBEB_OFS_BULK_TWO_TOGGLE 8'h18
`define USBEB_OFS_EP2MP 8'h19
`define USBEB_OFS_EP2CNT 8'h1a
`define USBEB_OFS_EP2BUF 8'h1b
`define USBEB_OFS_DMACTL 8'h1c
// packet ready bit positions
`define USBEB_PR_EP0_RX 0
`define USBEB_PR_EP1_RX 1
`define USBEB_PR_EP2_RX 2
`define USBEB_PR_EP0_TX 4
`define USBEB_PR_EP1_TX 5
`define USBEB_PR_EP2_TX 6
// interrupt status / enable bit positions
`define USBEB_IS_SETUP 0
`define USBEB_IS_EP1 1
`define USBEB_IS_EP2 2
`define USBEB_IS_EP0_RX 3
`define USBEB_IS_EP0_TX 4
// bulk config fields
`define USBEB_CFG_EN 7
`define USBEB_CFG_IN 6
`define USBEB_DMA_EN 0
// reset values
`define USBEB_RST_MP0 8'h08
`define USBEB_RST_MP1 7'h40
`define USBEB_RST_MP2 7'h40
`define USBEB_RST_CFG 8'h00
`endif

// ===== hw/usbeb_core.sv
// endpoint buffers, setup capture and packet signalling of a usb device
// assumes: serial engine on the same clock sends decoded packet events
`timescale 1ns/1ns
`include "usbeb_consts.svh"
// Overview of operation
// - endpoint zero control data passes through one eight byte fifo
// - control transfer starts only on a setup request, whatever endpoint number it carries
// - control read, control write and no-data control forms are tracked
// - eight setup bytes latched; setup flag, status and enable at bit 0
// - ep0 ready at D0/D4, irq bits D3/D4, 4-bit count, 8-bit max packet
// - standard requests reach firmware through setup registers
// - two bulk endpoints, one and two
// - each bulk endpoint chooses in or out direction
// - bulk endpoint two holds sixty-four bytes, endpoint one twice that in two layers
// - only bulk endpoint one raises dma requests
// - endpoint one has two layers, processor and bus alternate
// - ep1 ready D1/D5, irq D1, toggle D0, 7-bit sizes, fifo D3..D2
// - ep2 ready D2/D6, irq D2, toggle D0, 7-bit sizes, fifo D3..D2
// - transmit ready clears after data sent and host acknowledged
// - receive ready sets after good packet acknowledged
module usbeb_core #(
  parameter int EP0_DEPTH = 8,
  parameter int BULK_DEPTH = 64
) (
  input wire logic clk,
  input wire logic reset,
  input wire usbeb_pkg::usbeb_bus_t bus,
  output logic [7:0] rdata,
  input wire usbeb_pkg::usbeb_evt_t usb_in,
  output usbeb_pkg::usbeb_stat_t usb_out,
  output logic irq,
  output logic dma_req
);
  localparam int C0 = $clog2(EP0_DEPTH + 1);
  localparam int CB = $clog2(BULK_DEPTH + 1);

  logic [7:0] setup_r [8];
  logic [2:0] sidx_r;
  logic setup_rdy_r;
  usbeb_pkg::usbeb_stage_t st_r;
  logic rdy0_rx_r, rdy0_tx_r, rdy2_rx_r, rdy2_tx_r;
  logic [1:0] full1_r;
  logic cl_r, ul_r;
  logic [4:0] ist_r, ien_r;
  logic [1:0] tgl0_r;
  logic tgl1_r, tgl2_r;
  logic [7:0] mp0_r, cfg1_r, cfg2_r, dmac_r;
  logic [6:0] mp1_r, mp2_r;
  logic [7:0] rdata_r, rd_nxt;
  usbeb_pkg::usbeb_stat_t uo_r;
  logic irq_r, dma_r;

  // register strobes
  wire logic w_st = bus.wr && bus.addr == `USBEB_OFS_EP0STAT;
  wire logic w_pr = bus.wr && bus.addr == `USBEB_OFS_PR;
  wire logic w_ist = bus.wr && bus.addr == `USBEB_OFS_IST;
  wire logic w_ien = bus.wr && bus.addr == `USBEB_OFS_IEN;
  wire logic w_t0 = bus.wr && bus.addr == `USBEB_OFS_EP0TGL;
  wire logic w_mp0 = bus.wr && bus.addr == `USBEB_OFS_EP0MP;
  wire logic w_b0 = bus.wr && bus.addr == `USBEB_OFS_EP0BUF;
  wire logic w_c1 = bus.wr && bus.addr == `USBEB_OFS_EP1CFG;
  wire logic w_t1 = bus.wr && bus.addr == `USBEB_OFS_BULK_ONE_TOGGLE;
  wire logic w_mp1 = bus.wr && bus.addr == `USBEB_OFS_EP1MP;
  wire logic w_b1 = bus.wr && bus.addr == `USBEB_OFS_EP1BUF;
  wire logic w_c2 = bus.wr && bus.addr == `USBEB_OFS_EP2CFG;
  wire logic w_t2 = bus.wr && bus.addr == `USBEB_OFS_BULK_TWO_TOGGLE;
  wire logic w_mp2 = bus.wr && bus.addr == `USBEB_OFS_EP2MP;
  wire logic w_b2 = bus.wr && bus.addr == `USBEB_OFS_EP2BUF;
  wire logic w_dma = bus.wr && bus.addr == `USBEB_OFS_DMACTL;
  wire logic r_b0 = bus.rd && bus.addr == `USBEB_OFS_EP0BUF;
  wire logic r_b1 = bus.rd && bus.addr == `USBEB_OFS_EP1BUF;
  wire logic r_b2 = bus.rd && bus.addr == `USBEB_OFS_EP2BUF;

  // direction of each endpoint
  wire logic in0 = (st_r == usbeb_pkg::ST_DIN) ||
                   (st_r == usbeb_pkg::ST_SIN);
  wire logic en1 = cfg1_r[`USBEB_CFG_EN];
  wire logic in1 = cfg1_r[`USBEB_CFG_IN];
  wire logic en2 = cfg2_r[`USBEB_CFG_EN];
  wire logic in2 = cfg2_r[`USBEB_CFG_IN];

  wire logic e0 = usb_in.ep == 2'd0;
  wire logic e1 = usb_in.ep == 2'd1;
  wire logic e2 = usb_in.ep == 2'd2;

  // buffer wires
  logic [7:0] b0_q, b2_q;
  logic [C0-1:0] b0_cnt;
  logic [CB-1:0] b2_cnt;
  logic b0_empty, b0_full, b2_empty, b2_full;
  logic [7:0] b1_q [2];
  logic [CB-1:0] b1_cnt [2];
  logic [1:0] b1_wr, b1_rd, b1_clr;

  // ep0 out packets only in the data-out phase (ST_DOUT)
  wire logic room0 = !in0 && !rdy0_rx_r && st_r != usbeb_pkg::ST_IDLE;
  wire logic room1 = en1 && !in1 && !full1_r[ul_r];
  wire logic room2 = en2 && !in2 && !rdy2_rx_r;
  wire logic rx0_good = usb_in.rx_good && e0 && room0;
  wire logic rx1_good = usb_in.rx_good && e1 && room1;
  wire logic rx2_good = usb_in.rx_good && e2 && room2;
  wire logic tx0_ack = usb_in.tx_ack && e0 && rdy0_tx_r;
  wire logic tx1_ack = usb_in.tx_ack && e1 && en1 && in1 &&
                       full1_r[ul_r];
  wire logic tx2_ack = usb_in.tx_ack && e2 && en2 && in2 &&
                       rdy2_tx_r;
  wire logic rel0 = w_pr && bus.wdata[`USBEB_PR_EP0_RX];
  wire logic rel1 = w_pr && bus.wdata[`USBEB_PR_EP1_RX];
  wire logic rel2 = w_pr && bus.wdata[`USBEB_PR_EP2_RX];
  wire logic go0 = w_pr && bus.wdata[`USBEB_PR_EP0_TX];
  wire logic go1 = w_pr && bus.wdata[`USBEB_PR_EP1_TX];
  wire logic go2 = w_pr && bus.wdata[`USBEB_PR_EP2_TX];

  // bytes beyond the max packet size are dropped on receive
  wire logic acc0 = usb_in.rx_wr && e0 && room0 &&
                    ({{(8-C0){1'b0}}, b0_cnt} < mp0_r);
  wire logic acc1 = usb_in.rx_wr && e1 && room1 &&
                    (b1_cnt[ul_r] < mp1_r);
  wire logic acc2 = usb_in.rx_wr && e2 && room2 && (b2_cnt < mp2_r);

  usbeb_buf #(.DEPTH(EP0_DEPTH), .CW(C0)) u_ep0 (
    .clk(clk),
    .reset(reset),
    .clr(usb_in.setup_done || (rel0 && !in0) ||
         (usb_in.rx_bad && e0 && room0)),
    .wr(in0 ? (w_b0 && !rdy0_tx_r) : acc0),
    .wdata(in0 ? bus.wdata : usb_in.data),
    .rd(in0 ? (usb_in.tx_rd && e0) : r_b0),
    .rdata(b0_q),
    .count(b0_cnt),
    .empty(b0_empty),
    .full(b0_full)
  );

  // two layers: processor owns cl_r, bus owns ul_r
  for (genvar l = 0; l < 2; l++) begin : g_lay
    assign b1_wr[l] = in1 ? (w_b1 && cl_r == l && !full1_r[l])
                          : (acc1 && ul_r == l);
    assign b1_rd[l] = in1 ? (usb_in.tx_rd && e1 && ul_r == l)
                          : (r_b1 && cl_r == l);
    assign b1_clr[l] = (!in1 && rel1 && cl_r == l && full1_r[l]) ||
                       (usb_in.rx_bad && e1 && room1 && ul_r == l);
    usbeb_buf #(.DEPTH(BULK_DEPTH), .CW(CB)) u_ep1 (
      .clk(clk),
      .reset(reset),
      .clr(b1_clr[l]),
      .wr(b1_wr[l]),
      .wdata(in1 ? bus.wdata : usb_in.data),
      .rd(b1_rd[l]),
      .rdata(b1_q[l]),
      .count(b1_cnt[l]),
      .empty(),
      .full()
    );
  end

  usbeb_buf #(.DEPTH(BULK_DEPTH), .CW(CB)) u_ep2 (
    .clk(clk),
    .reset(reset),
    .clr((!in2 && rel2) || (usb_in.rx_bad && e2 && room2)),
    .wr(in2 ? (w_b2 && !rdy2_tx_r) : acc2),
    .wdata(in2 ? bus.wdata : usb_in.data),
    .rd(in2 ? (usb_in.tx_rd && e2) : r_b2),
    .rdata(b2_q),
    .count(b2_cnt),
    .empty(b2_empty),
    .full(b2_full)
  );

  // setup capture
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sidx_r <= 3'h0;
      for (int i = 0; i < 8; i++) begin
        setup_r[i] <= 8'h00;
      end
    end else if (usb_in.setup_done || usb_in.rx_bad) begin
      sidx_r <= 3'h0;
    end else if (usb_in.setup_wr) begin
      setup_r[sidx_r] <= usb_in.data;
      sidx_r <= sidx_r + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      setup_rdy_r <= 1'b0;
    end else if (usb_in.setup_done) begin
      setup_rdy_r <= 1'b1;
    end else if (w_st && bus.wdata[0]) begin
      setup_rdy_r <= 1'b0;
    end
  end

  // control stage tracking
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= usbeb_pkg::ST_IDLE;
    end else if (usb_in.setup_done) begin
      if ({setup_r[7], setup_r[6]} == 16'h0000) begin
        st_r <= usbeb_pkg::ST_SIN;
      end else if (setup_r[0][7]) begin
        st_r <= usbeb_pkg::ST_DIN;
      end else begin
        st_r <= usbeb_pkg::ST_DOUT;
      end
    end else begin
      unique case (st_r)
        usbeb_pkg::ST_IDLE: st_r <= usbeb_pkg::ST_IDLE;
        // host status out packet ends a control read
        usbeb_pkg::ST_DIN: if (usb_in.rx_good && e0) begin
          st_r <= usbeb_pkg::ST_IDLE;
        end
        usbeb_pkg::ST_DOUT: if (tx0_ack) begin
          st_r <= usbeb_pkg::ST_IDLE;
        end
        usbeb_pkg::ST_SIN: if (tx0_ack) begin
          st_r <= usbeb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ep0 and ep2 packet ready; hardware set wins over processor clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdy0_rx_r <= 1'b0;
      rdy0_tx_r <= 1'b0;
    end else if (usb_in.setup_done) begin
      rdy0_rx_r <= 1'b0;
      rdy0_tx_r <= 1'b0;
    end else begin
      rdy0_rx_r <= rx0_good || (rdy0_rx_r && !rel0);
      rdy0_tx_r <= go0 || (rdy0_tx_r && !tx0_ack);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdy2_rx_r <= 1'b0;
      rdy2_tx_r <= 1'b0;
    end else begin
      rdy2_rx_r <= rx2_good || (rdy2_rx_r && !rel2);
      rdy2_tx_r <= (go2 && in2) || (rdy2_tx_r && !tx2_ack);
    end
  end

  // ep1 layer ownership
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      full1_r <= 2'b00;
      cl_r <= 1'b0;
      ul_r <= 1'b0;
    end else if (w_c1) begin
      full1_r <= 2'b00;
      cl_r <= 1'b0;
      ul_r <= 1'b0;
    end else begin
      if (rx1_good || tx1_ack) begin
        full1_r[ul_r] <= rx1_good;
        ul_r <= !ul_r;
      end
      if ((in1 ? go1 : rel1) && (full1_r[cl_r] != in1)) begin
        full1_r[cl_r] <= in1;
        cl_r <= !cl_r;
      end
    end
  end

  // data toggles
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tgl0_r <= 2'b00;
      tgl1_r <= 1'b0;
      tgl2_r <= 1'b0;
    end else begin
      if (usb_in.setup_done) begin
        tgl0_r <= 2'b11;
      end else if (rx0_good || tx0_ack) begin
        tgl0_r <= tgl0_r ^ {tx0_ack, rx0_good};
      end else if (w_t0) begin
        tgl0_r <= bus.wdata[1:0];
      end
      if (rx1_good || tx1_ack) begin
        tgl1_r <= !tgl1_r;
      end else if (w_t1) begin
        tgl1_r <= bus.wdata[0];
      end
      if (rx2_good || tx2_ack) begin
        tgl2_r <= !tgl2_r;
      end else if (w_t2) begin
        tgl2_r <= bus.wdata[0];
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mp0_r <= `USBEB_RST_MP0;
      mp1_r <= `USBEB_RST_MP1;
      mp2_r <= `USBEB_RST_MP2;
      cfg1_r <= `USBEB_RST_CFG;
      cfg2_r <= `USBEB_RST_CFG;
      dmac_r <= 8'h00;
      ien_r <= 5'h00;
    end else begin
      if (w_mp0) mp0_r <= bus.wdata;
      if (w_mp1) mp1_r <= bus.wdata[6:0];
      if (w_mp2) mp2_r <= bus.wdata[6:0];
      if (w_c1) cfg1_r <= bus.wdata;
      if (w_c2) cfg2_r <= bus.wdata;
      if (w_dma) dmac_r <= bus.wdata;
      if (w_ien) ien_r <= bus.wdata[4:0];
    end
  end

  // sticky interrupt status, write one to clear, new event wins
  wire logic [4:0] ev = {tx0_ack, rx0_good, rx2_good || tx2_ack,
                         rx1_good || tx1_ack, usb_in.setup_done};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ist_r <= 5'h00;
    end else begin
      ist_r <= (ist_r & ~(w_ist ? bus.wdata[4:0] : 5'h00)) | ev;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_r <= 1'b0;
      dma_r <= 1'b0;
    end else begin
      irq_r <= |(ist_r & ien_r);
      // dma follows the processor layer: free when in, full when out
      dma_r <= dmac_r[`USBEB_DMA_EN] && en1 &&
               (full1_r[cl_r] != in1);
    end
  end

  // answers to the serial engine; one cycle behind the state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      uo_r <= '0;
    end else begin
      uo_r.rx_room <= {room2, room1, room0};
      uo_r.tx_full <= {en2 && in2 && rdy2_tx_r,
                       en1 && in1 && full1_r[ul_r], rdy0_tx_r};
      if (usb_in.tx_rd) begin
        uo_r.tx_byte <= e0 ? b0_q : (e1 ? b1_q[ul_r] : b2_q);
      end
    end
  end

  // register read mux, unmapped addresses read zero
  always_comb begin
    rd_nxt = 8'h00;
    if (bus.addr <= `USBEB_OFS_SETUP7) begin
      rd_nxt = setup_r[bus.addr[2:0]];
    end else begin
      unique case (bus.addr)
        `USBEB_OFS_EP0STAT: rd_nxt = {3'h0, st_r, 1'b0, setup_rdy_r};
        `USBEB_OFS_PR: rd_nxt = {1'b0, rdy2_tx_r,
                                 in1 && full1_r[cl_r], rdy0_tx_r,
                                 1'b0, rdy2_rx_r,
                                 !in1 && full1_r[cl_r], rdy0_rx_r};
        `USBEB_OFS_IST: rd_nxt = {3'h0, ist_r};
        `USBEB_OFS_IEN: rd_nxt = {3'h0, ien_r};
        `USBEB_OFS_EP0TGL: rd_nxt = {6'h00, tgl0_r};
        `USBEB_OFS_EP0MP: rd_nxt = mp0_r;
        `USBEB_OFS_EP0CNT: rd_nxt = {{(8-C0){1'b0}}, b0_cnt};
        `USBEB_OFS_FST1: rd_nxt = {4'h0, full1_r, b0_full, b0_empty};
        `USBEB_OFS_FST2: rd_nxt = {4'h0, b2_full, b2_empty, 2'b00};
        `USBEB_OFS_EP0BUF: rd_nxt = b0_q;
        `USBEB_OFS_EP1CFG: rd_nxt = cfg1_r;
        `USBEB_OFS_BULK_ONE_TOGGLE: rd_nxt = {7'h00, tgl1_r};
        `USBEB_OFS_EP1MP: rd_nxt = {1'b0, mp1_r};
        `USBEB_OFS_EP1CNT: rd_nxt = {1'b0, b1_cnt[cl_r][6:0]};
        `USBEB_OFS_EP1BUF: rd_nxt = b1_q[cl_r];
        `USBEB_OFS_EP2CFG: rd_nxt = cfg2_r;
        `USBEB_OFS_BULK_TWO_TOGGLE: rd_nxt = {7'h00, tgl2_r};
        `USBEB_OFS_EP2MP: rd_nxt = {1'b0, mp2_r};
        `USBEB_OFS_EP2CNT: rd_nxt = {1'b0, b2_cnt[6:0]};
        `USBEB_OFS_EP2BUF: rd_nxt = b2_q;
        `USBEB_OFS_DMACTL: rd_nxt = dmac_r;
        default: rd_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= bus.rd ? rd_nxt : 8'h00;
    end
  end

  assign rdata = rdata_r;
  assign usb_out = uo_r;
  assign irq = irq_r;
  assign dma_req = dma_r;
endmodule : usbeb_core

// ===== hw/usbeb_pkg.sv
// types shared by the endpoint buffer control block
// assumes: constants come from usbeb_consts.svh
package usbeb_pkg;
  // register port from the local processor
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } usbeb_bus_t;
  // events from the serial engine, same clock
  typedef struct packed {
    logic setup_wr;
    logic setup_done;
    logic rx_wr;
    logic rx_good;
    logic rx_bad;
    logic tx_rd;
    logic tx_ack;
    logic [1:0] ep;
    logic [7:0] data;
  } usbeb_evt_t;
  // answers to the serial engine
  typedef struct packed {
    logic [2:0] rx_room;
    logic [2:0] tx_full;
    logic [7:0] tx_byte;
  } usbeb_stat_t;
  typedef enum logic [2:0] {ST_IDLE, ST_DIN, ST_DOUT, ST_SIN} usbeb_stage_t;
endpackage : usbeb_pkg

// ===== sim/test_usb_endpoint_buffer_control.sv
// self-checking bench for the endpoint buffer core
// assumes: usbeb_host drives the serial events
`timescale 1ns/1ns
module test_usb_endpoint_buffer_control;
  logic clk;
  logic reset;
  usbeb_pkg::usbeb_bus_t bus;
  usbeb_pkg::usbeb_evt_t usb_in;
  usbeb_pkg::usbeb_stat_t usb_out;
  logic [7:0] rdata;
  logic irq;
  logic dma_req;
  logic [5:0] lv;
  int fail_count;
  int total_checks;
  int cyc;
  assign lv = {usb_out.tx_full, usb_out.rx_room};
  usbeb_core dut (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
    .usb_in(usb_in), .usb_out(usb_out), .irq(irq), .dma_req(dma_req));
  usbeb_host host (.clk(clk), .usb_in(usb_in), .usb_out(usb_out));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  // generous ceiling, the run needs well under a tenth of it
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask : wr
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    cmp(rdata, e);
    @(posedge clk);
  endtask : chk
  task automatic pins(input logic [1:0] e);
    @(negedge clk);
    cmp({6'h00, irq, dma_req}, {6'h00, e});
    @(posedge clk);
  endtask : pins
  task automatic waitb(input int i, input logic v);
    int n;
    n = 0;
    // settled levels only, never the edge that launches them
    @(negedge clk);
    while (lv[i] !== v && n < 50) begin
      @(negedge clk);
      n++;
    end
    cmp({7'h00, lv[i]}, {7'h00, v});
    @(posedge clk);
  endtask : waitb
  task automatic su(input logic [63:0] b);
    host.setup(b);
    for (int i = 0; i < 8; i++) chk(8'(i), b[8*i +: 8]);
  endtask : su
  task automatic t_reset_vals;
    chk(8'h0d, 8'h08);
    chk(8'h14, 8'h40);
    chk(8'h19, 8'h40);
    chk(8'h12, 8'h00);
    chk(8'h3f, 8'h00);
  endtask : t_reset_vals
  task automatic t_no_data;
    wr(8'h0b, 8'h01);
    su(64'h0000_0000_0012_0500);
    chk(8'h08, 8'h0d);
    chk(8'h0a, 8'h01);
    pins(2'h2);
    wr(8'h0b, 8'h00);
    pins(2'h0);
    wr(8'h0b, 8'h01);
    pins(2'h2);
    wr(8'h0a, 8'hff);
    wr(8'h08, 8'h01);
    pins(2'h0);
    wr(8'h09, 8'h10);
    waitb(3, 1'b1);
    host.take_in(2'h0, 0);
    chk(8'h09, 8'h00);
    chk(8'h0a, 8'h10);
    chk(8'h08, 8'h00);
    wr(8'h0a, 8'hff);
  endtask : t_no_data
  task automatic t_ctl_read;
    su(64'h0002_0000_0100_0680);
    chk(8'h08, 8'h05);
    wr(8'h0a, 8'hff);
    wr(8'h08, 8'h01);
    wr(8'h11, 8'ha1);
    wr(8'h11, 8'ha2);
    wr(8'h09, 8'h10);
    waitb(3, 1'b1);
    host.take_in(2'h0, 2);
    cmp(host.got[0], 8'ha1);
    cmp(host.got[1], 8'ha2);
    chk(8'h09, 8'h00);
    chk(8'h0c, 8'h01);
    wr(8'h0a, 8'hff);
  endtask : t_ctl_read
  task automatic t_ctl_write;
    su(64'h0002_0000_0000_0900);
    chk(8'h08, 8'h09);
    wr(8'h0a, 8'hff);
    wr(8'h08, 8'h01);
    waitb(0, 1'b1);
    host.send_out(2'h0, 2, 8'h30);
    chk(8'h09, 8'h01);
    chk(8'h0e, 8'h02);
    chk(8'h11, 8'h30);
    chk(8'h11, 8'h31);
    wr(8'h09, 8'h01);
    wr(8'h0a, 8'hff);
  endtask : t_ctl_write
  task automatic t_ep2_out;
    wr(8'h17, 8'h80);
    waitb(2, 1'b1);
    host.send_out(2'h2, 3, 8'h50);
    waitb(2, 1'b0);
    chk(8'h09, 8'h04);
    chk(8'h0a, 8'h04);
    chk(8'h18, 8'h01);
    chk(8'h1a, 8'h03);
    for (int i = 0; i < 3; i++) chk(8'h1b, 8'h50 + 8'(i));
    wr(8'h09, 8'h04);
    waitb(2, 1'b1);
    // a damaged packet leaves no bytes and no ready flag behind
    host.ev(7'h10, 2'h2, 8'h77);
    host.ev(7'h04, 2'h2, 8'h00);
    host.idle();
    chk(8'h1a, 8'h00);
    chk(8'h09, 8'h00);
    chk(8'h10, 8'h04);
    wr(8'h0a, 8'hff);
  endtask : t_ep2_out
  task automatic t_ep1_dma;
    wr(8'h12, 8'hc0);
    wr(8'h1c, 8'h01);
    pins(2'h1);
    for (int i = 0; i < 64; i++) wr(8'h16, 8'(i));
    wr(8'h09, 8'h20);
    for (int i = 0; i < 64; i++) wr(8'h16, 8'(i + 64));
    // second commit: both layers now wait for the bus
    wr(8'h09, 8'h20);
    pins(2'h0);
    chk(8'h0f, 8'h0d);
    waitb(4, 1'b1);
    host.take_in(2'h1, 64);
    cmp(host.got[0], 8'h00);
    cmp(host.got[63], 8'h3f);
    chk(8'h13, 8'h01);
  endtask : t_ep1_dma
  initial begin
    reset = 1'b1;
    bus = '0;
    fail_count = 0;
    total_checks = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset_vals();
    t_no_data();
    t_ctl_read();
    t_ctl_write();
    t_ep2_out();
    t_ep1_dma();
    close_out();
  end
endmodule : test_usb_endpoint_buffer_control

// ===== sim/usbeb_host.sv
// serial engine stand-in: host packets as one-cycle event pulses
// assumes: called at a rising edge; same clock as the core
`timescale 1ns/1ns
module usbeb_host (
  input wire logic clk,
  output usbeb_pkg::usbeb_evt_t usb_in,
  input wire usbeb_pkg::usbeb_stat_t usb_out
);
  localparam logic [6:0] k_sw = 7'h40;
  localparam logic [6:0] k_sd = 7'h20;
  localparam logic [6:0] k_rw = 7'h10;
  localparam logic [6:0] k_rg = 7'h08;
  localparam logic [6:0] k_tr = 7'h02;
  localparam logic [6:0] k_ta = 7'h01;
  logic [7:0] got[$];
  logic [7:0] last;
  logic pend;
  initial begin
    usb_in = '0;
    last = 8'h00;
    pend = 1'b0;
  end
  // popped bytes settle one cycle after the pop
  always @(negedge clk) begin
    if (pend) got.push_back(usb_out.tx_byte);
    pend = usb_in.tx_rd;
  end
  task automatic ev(input logic [6:0] k, input logic [1:0] ep,
                    input logic [7:0] d);
    usb_in <= {k, ep, d};
    last = d;
    @(posedge clk);
  endtask : ev
  // data lines show no stale byte between packets
  task automatic idle;
    ev(7'h00, 2'h0, ~last);
  endtask : idle
  task automatic setup(input logic [63:0] b);
    for (int i = 0; i < 8; i++) ev(k_sw, 2'h0, b[8*i +: 8]);
    ev(k_sd, 2'h0, 8'h00);
    idle();
  endtask : setup
  task automatic send_out(input logic [1:0] ep, input int n,
                          input logic [7:0] b);
    for (int i = 0; i < n; i++) ev(k_rw, ep, b + 8'(i));
    ev(k_rg, ep, 8'h00);
    idle();
  endtask : send_out
  task automatic take_in(input logic [1:0] ep, input int n);
    got.delete();
    repeat (n) ev(k_tr, ep, 8'h00);
    ev(k_ta, ep, 8'h00);
    idle();
  endtask : take_in
endmodule : usbeb_host

// ===== sim/usbeb_props.sv
// assertions on the endpoint buffer core ports
// assumes: one clock, async high reset, bound to usbeb_core
`timescale 1ns/1ns
`include "usbeb_consts.svh"
module usbeb_props #(
  parameter int EP0_DEPTH = 8,
  parameter int BULK_DEPTH = 64
) (
  input wire logic clk,
  input wire logic reset,
  input wire usbeb_pkg::usbeb_bus_t bus,
  input wire logic [7:0] rdata,
  input wire usbeb_pkg::usbeb_evt_t usb_in,
  input wire usbeb_pkg::usbeb_stat_t usb_out,
  input wire logic irq,
  input wire logic dma_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_ack0;
    usb_in.tx_ack && usb_in.ep == 2'h0 && usb_out.tx_full[0];
  endsequence
  sequence s_good2;
    usb_in.rx_good && usb_in.ep == 2'h2 && usb_out.rx_room[2];
  endsequence
  property p_rd_idle;
    !bus.rd |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_reset_quiet;
    $fell(reset) |-> !irq && !dma_req && usb_out.tx_full == 3'h0
      && usb_out.rx_room == 3'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
  property p_tx_clear;
    s_ack0 |-> ##2 !usb_out.tx_full[0];
  endproperty
  a_tx_clear: assert property (p_tx_clear)
    else $error("tx ready kept after ack");
  property p_room_drop;
    s_good2 |-> ##2 !usb_out.rx_room[2];
  endproperty
  a_room_drop: assert property (p_room_drop)
    else $error("room kept after good packet");
  property p_room_rise;
    $rose(usb_out.rx_room[2]) |-> $past(bus.wr) || $past(bus.wr, 2);
  endproperty
  a_room_rise: assert property (p_room_rise)
    else $error("room returned without release");
  property p_tx_rise;
    $rose(usb_out.tx_full[0]) |-> $past(bus.wr) || $past(bus.wr, 2);
  endproperty
  a_tx_rise: assert property (p_tx_rise)
    else $error("tx ready without commit");
  property p_setup_clr;
    usb_in.setup_done |-> ##2 !usb_out.tx_full[0];
  endproperty
  a_setup_clr: assert property (p_setup_clr)
    else $error("setup left ep0 tx ready");
  property p_byte_hold;
    !usb_in.tx_rd |=> $stable(usb_out.tx_byte);
  endproperty
  a_byte_hold: assert property (p_byte_hold)
    else $error("tx byte moved without pop");
  property p_irq_off;
    bus.wr && bus.addr == `USBEB_OFS_IEN && bus.wdata == 8'h00 |-> ##2 !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("irq with all sources masked");
endmodule : usbeb_props
bind usbeb_core usbeb_props #(
  .EP0_DEPTH(EP0_DEPTH),
  .BULK_DEPTH(BULK_DEPTH)
) u_props (
  .clk(clk),
  .reset(reset),
  .bus(bus),
  .rdata(rdata),
  .usb_in(usb_in),
  .usb_out(usb_out),
  .irq(irq),
  .dma_req(dma_req)
);
